// >>> core/ast_pkg.sv
// Constants, types and helpers shared by the ADC self-test block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned register indices.
package ast_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CTRL      = 10'h021;
  localparam logic [9:0]  IDX_SUBST     = 10'h022;
  localparam logic [9:0]  IDX_FAULT     = 10'h061;
  localparam logic [9:0]  IDX_IRQ_STAT  = 10'h070;
  localparam logic [9:0]  IDX_IRQ_MASK  = 10'h071;
  localparam int          AXI_AW        = 12;
  // Control register fields
  localparam int          CTRL_FULL_BIT = 4;
  localparam int          CTRL_PART_BIT = 3;
  localparam int          CTRL_DTRIP    = 2;
  localparam int          CTRL_ATRIP    = 1;
  localparam int          CTRL_OCTRIP   = 0;
  // Substitution register fields
  localparam int          SUBST_EN_BIT  = 23;
  localparam int          SUBST_W       = 14;
  localparam logic [13:0] SUBST_RST     = 14'h0000;
  localparam logic [13:0] CONV_MAX      = 14'h1fff;
  localparam logic [13:0] CONV_MIN      = 14'h2000;
  // Fault and interrupt fields
  localparam int          FAULT_CAL_BIT = 4;
  localparam int          IRQ_DONE_BIT  = 0;
  localparam int          IRQ_FAIL_BIT  = 1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {AST_CAL_IDLE, AST_CAL_FULL, AST_CAL_PART} ast_cal_state_t;

  // Two's-complement add clipped to the 14-bit code range
  function automatic logic [13:0] ast_sat_add(input logic [13:0] a, input logic [13:0] b);
    logic [14:0] sum;
    sum = {a[13], a} + {b[13], b};
    if (sum[14] != sum[13]) begin
      ast_sat_add = sum[14] ? CONV_MIN : CONV_MAX;
    end else begin
      ast_sat_add = sum[13:0];
    end
  endfunction : ast_sat_add

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] ast_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    ast_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) ast_merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction : ast_merge
endpackage : ast_pkg

// >>> core/ast_cal_if.sv
// Carrier between the register side and the calibration sequencer.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface ast_cal_if;
  logic req_full;   // One-cycle request, full test
  logic req_part;   // One-cycle request, partial test
  logic full_busy;
  logic part_busy;
  logic finish;     // One-cycle, test ended
  logic fault;      // Calibration fault level
  modport ctrl (output req_full, req_part, input full_busy, part_busy, finish, fault);
  modport seq  (input req_full, req_part, output full_busy, part_busy, finish, fault);
endinterface : ast_cal_if

// >>> core/ast_cal_seq.sv
// Calibration test sequencer: full and partial tests and their fault result.
// Assumes the calibration engine runs on clk_sys and pulses done once per start.
`timescale 1ns/1ps
module ast_cal_seq (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  ast_cal_if.seq          cal,
  output logic            eng_start,
  output logic            eng_abort,
  output logic            eng_partial,
  output logic            eng_store_enable,
  input  wire logic       eng_done,
  input  wire logic       eng_pass
);
  typedef struct packed {
    ast_pkg::ast_cal_state_t state;
    logic                    start;
    logic                    abort;
    logic                    finish;
    logic                    fault;
  } ast_seq_state_t;

  ast_seq_state_t s;
  ast_seq_state_t next_s;

  // Next state; full always outranks partial
  always_comb begin
    next_s        = s;
    next_s.start  = 1'b0;
    next_s.abort  = 1'b0;
    next_s.finish = 1'b0;
    unique case (s.state)
      ast_pkg::AST_CAL_IDLE: begin
        if (cal.req_full) begin
          next_s.state = ast_pkg::AST_CAL_FULL;
          next_s.start = 1'b1;
        end else if (cal.req_part) begin
          next_s.state = ast_pkg::AST_CAL_PART;
          next_s.start = 1'b1;
        end
      end
      ast_pkg::AST_CAL_FULL: begin
        if (eng_done) begin
          next_s.state  = ast_pkg::AST_CAL_IDLE;
          next_s.finish = 1'b1;
          next_s.fault  = !eng_pass;
        end
      end
      ast_pkg::AST_CAL_PART: begin
        if (cal.req_full) begin
          next_s.state = ast_pkg::AST_CAL_FULL;
          next_s.abort = 1'b1;
          next_s.start = 1'b1;
        end else if (eng_done) begin
          next_s.state  = ast_pkg::AST_CAL_IDLE;
          next_s.finish = 1'b1;
          next_s.fault  = !eng_pass;
        end
      end
      // Unused code falls back to idle
      default: begin
        next_s.state = ast_pkg::AST_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '{state: ast_pkg::AST_CAL_IDLE, default: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Partial runs compare only, so stored trims stay untouched
  assign eng_store_enable = (s.state == ast_pkg::AST_CAL_FULL);
  assign eng_partial      = (s.state == ast_pkg::AST_CAL_PART);
  assign eng_start        = s.start;
  assign eng_abort        = s.abort;
  assign cal.full_busy    = (s.state == ast_pkg::AST_CAL_FULL);
  assign cal.part_busy    = (s.state == ast_pkg::AST_CAL_PART);
  assign cal.finish       = s.finish;
  assign cal.fault        = s.fault;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_part_hit_by_full;
    cal.part_busy && cal.req_full;
  endsequence
  sequence s_full_takes_over;
    cal.full_busy && !cal.part_busy && eng_abort && eng_start;
  endsequence
  property p_abort_partial;
    s_part_hit_by_full |=> s_full_takes_over;
  endproperty
  a_abort_partial: assert property (p_abort_partial) else $error("partial not aborted by full");
  property p_ignore_partial;
    cal.full_busy && cal.req_part && !eng_done |=> cal.full_busy && !cal.part_busy && !eng_start;
  endproperty
  a_ignore_partial: assert property (p_ignore_partial) else $error("partial taken during full");
  property p_self_clear;
    (cal.full_busy || cal.part_busy) && eng_done && !cal.req_full |=> !cal.full_busy && !cal.part_busy && cal.finish;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("busy bit did not clear");
  property p_fault_value;
    cal.finish |-> cal.fault == !$past(eng_pass);
  endproperty
  a_fault_value: assert property (p_fault_value) else $error("fault not equal to result");
  property p_fault_when;
    $changed(cal.fault) |-> cal.finish;
  endproperty
  a_fault_when: assert property (p_fault_when) else $error("fault moved outside finish");
  property p_partial_nostore;
    cal.part_busy |-> !eng_store_enable && eng_partial;
  endproperty
  a_partial_nostore: assert property (p_partial_nostore) else $error("partial may store");
endmodule : ast_cal_seq

// >>> core/ast_self_test.sv
// ADC and protection self-test block with its AXI4-Lite register slave.
// Assumes ADC, trim and calibration engine signals come from clk_sys logic.
// What this block does
// - Full calibration test reports result in fault
// - Test bits read one while busy, self-clear
// - Full request aborts partial, starts full
// - Partial test compares only, stored values kept
// - Partial request during full is ignored
// - Digital die thermal trip forces shutdown
// - Analog die thermal trip forces shutdown
// - Transistor overcurrent trip forces power-down
// - Substitute value replaces result, conversions continue
// - Substitute is 14-bit two's complement
// - Substitute value resets to zero
// - Channel trim applied to substitute value
`timescale 1ns/1ps
module ast_self_test (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter path
  input  wire logic        adc_raw_valid,
  input  wire logic [13:0] adc_raw,
  input  wire logic [13:0] adc_trim,
  output logic             conv_valid,
  output logic [13:0]      conv_result,
  // Calibration engine
  output logic             cal_eng_start,
  output logic             cal_eng_abort,
  output logic             cal_eng_partial,
  output logic             cal_eng_store_enable,
  input  wire logic        cal_eng_done,
  input  wire logic        cal_eng_pass,
  // Protection trips and interrupt
  output logic             digital_die_thermal_trip,
  output logic             analog_die_thermal_trip,
  output logic             transistor_overcurrent_trip,
  output logic             irq
);
  typedef struct packed {
    logic                    aw_held;
    logic [11:0]             awaddr;
    logic                    w_held;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic [2:0]              trip;
    logic                    subst_en;
    logic [13:0]             subst_val;
    logic [1:0]              irq_stat;
    logic [1:0]              irq_mask;
    logic                    conv_valid;
    logic [13:0]             conv_result;
  } ast_top_state_t;

  ast_top_state_t s;
  ast_top_state_t next_s;
  logic           wr_fire;
  logic [9:0]     wr_idx;
  logic           ar_fire;
  logic [31:0]    rd;
  logic [31:0]    merged;
  logic [31:0]    subst_word;
  logic [13:0]    conv_pick;

  ast_cal_if cal ();

  // Sequencer owns the test state and the fault bit
  ast_cal_seq u_ast_cal_seq (
    .clk_sys          (clk_sys),
    .rstn             (rstn),
    .cal              (cal.seq),
    .eng_start        (cal_eng_start),
    .eng_abort        (cal_eng_abort),
    .eng_partial      (cal_eng_partial),
    .eng_store_enable (cal_eng_store_enable),
    .eng_done         (cal_eng_done),
    .eng_pass         (cal_eng_pass)
  );

  // Word index of a byte address
  function automatic logic [9:0] word_idx(input logic [11:0] addr);
    word_idx = addr[11:2];
  endfunction : word_idx

  // Stored substitute register as software sees it
  assign subst_word = {8'h00, s.subst_en, 9'h000, s.subst_val};

  // Bus slave, register effects, interrupts and converter path
  always_comb begin
    next_s       = s;
    cal.req_full = 1'b0;
    cal.req_part = 1'b0;
    rd           = 32'h0000_0000;
    merged       = ast_pkg::ast_merge(subst_word, s.wdata, s.wstrb);
    wr_idx       = word_idx(s.awaddr);
    wr_fire      = s.aw_held && s.w_held && !s.bvalid;
    ar_fire      = s_axi_arvalid && !s.rvalid;
    conv_pick    = s.subst_en ? s.subst_val : adc_raw;
    // Address and data are captured independently, in either order
    if (s_axi_awvalid && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = ast_pkg::RESP_OKAY;
      if (wr_idx == ast_pkg::IDX_CTRL) begin
        if (s.wstrb[0]) begin
          // Trips follow the written level; the device reset clears them
          next_s.trip[ast_pkg::CTRL_DTRIP]  = s.wdata[ast_pkg::CTRL_DTRIP];
          next_s.trip[ast_pkg::CTRL_ATRIP]  = s.wdata[ast_pkg::CTRL_ATRIP];
          next_s.trip[ast_pkg::CTRL_OCTRIP] = s.wdata[ast_pkg::CTRL_OCTRIP];
          cal.req_full = s.wdata[ast_pkg::CTRL_FULL_BIT];
          cal.req_part = s.wdata[ast_pkg::CTRL_PART_BIT];
        end
      end else if (wr_idx == ast_pkg::IDX_SUBST) begin
        // Reserved bits are dropped, so they never read back
        next_s.subst_en  = merged[ast_pkg::SUBST_EN_BIT];
        next_s.subst_val = merged[ast_pkg::SUBST_W-1:0];
      end else if (wr_idx == ast_pkg::IDX_IRQ_MASK) begin
        if (s.wstrb[0]) begin
          next_s.irq_mask = s.wdata[1:0];
        end
      end else if (wr_idx != ast_pkg::IDX_FAULT && wr_idx != ast_pkg::IDX_IRQ_STAT) begin
        next_s.bresp = ast_pkg::RESP_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = ast_pkg::RESP_OKAY;
      unique case (word_idx(s_axi_araddr))
        ast_pkg::IDX_CTRL: begin
          rd[ast_pkg::CTRL_FULL_BIT] = cal.full_busy;
          rd[ast_pkg::CTRL_PART_BIT] = cal.part_busy;
          rd[2:0]                    = s.trip;
        end
        ast_pkg::IDX_SUBST: begin
          rd = subst_word;
        end
        ast_pkg::IDX_FAULT: begin
          rd[ast_pkg::FAULT_CAL_BIT] = cal.fault;
        end
        ast_pkg::IDX_IRQ_STAT: begin
          // Read clears; an event in the same cycle is kept below
          rd[1:0]         = s.irq_stat;
          next_s.irq_stat = 2'h0;
        end
        ast_pkg::IDX_IRQ_MASK: begin
          rd[1:0] = s.irq_mask;
        end
        default: begin
          next_s.rresp = ast_pkg::RESP_SLVERR;
        end
      endcase
      next_s.rdata = rd;
    end
    // Events set after the clear, so a set wins
    if (cal.finish) begin
      next_s.irq_stat[ast_pkg::IRQ_DONE_BIT] = 1'b1;
      if (cal.fault) begin
        next_s.irq_stat[ast_pkg::IRQ_FAIL_BIT] = 1'b1;
      end
    end
    // Conversions keep running; only the value is swapped
    next_s.conv_valid = adc_raw_valid;
    if (adc_raw_valid) begin
      next_s.conv_result = ast_pkg::ast_sat_add(conv_pick, adc_trim);
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s           <= '0;
      s.subst_val <= ast_pkg::SUBST_RST;
      s.bresp     <= ast_pkg::RESP_OKAY;
      s.rresp     <= ast_pkg::RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  // Outputs; ready goes low while a beat is held
  assign s_axi_awready               = !s.aw_held;
  assign s_axi_wready                = !s.w_held;
  assign s_axi_arready               = !s.rvalid;
  assign s_axi_bvalid                = s.bvalid;
  assign s_axi_bresp                 = s.bresp;
  assign s_axi_rvalid                = s.rvalid;
  assign s_axi_rdata                 = s.rdata;
  assign s_axi_rresp                 = s.rresp;
  assign conv_valid                  = s.conv_valid;
  assign conv_result                 = s.conv_result;
  assign digital_die_thermal_trip    = s.trip[ast_pkg::CTRL_DTRIP];
  assign analog_die_thermal_trip     = s.trip[ast_pkg::CTRL_ATRIP];
  assign transistor_overcurrent_trip = s.trip[ast_pkg::CTRL_OCTRIP];
  assign irq                         = |(s.irq_stat & s.irq_mask);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_ctrl_write;
    wr_fire && wr_idx == ast_pkg::IDX_CTRL && s.wstrb[0];
  endsequence
  property p_dtrip;
    s_ctrl_write |=> digital_die_thermal_trip == $past(s.wdata[ast_pkg::CTRL_DTRIP]);
  endproperty
  a_dtrip: assert property (p_dtrip) else $error("digital trip not set by write");
  property p_atrip;
    s_ctrl_write |=> analog_die_thermal_trip == $past(s.wdata[ast_pkg::CTRL_ATRIP]);
  endproperty
  a_atrip: assert property (p_atrip) else $error("analog trip not set by write");
  property p_octrip;
    s_ctrl_write and s.wdata[ast_pkg::CTRL_OCTRIP] |=> transistor_overcurrent_trip[*2];
  endproperty
  a_octrip: assert property (p_octrip) else $error("overcurrent trip not held");
  property p_subst_used;
    adc_raw_valid && s.subst_en |=> conv_valid &&
      conv_result == ast_pkg::ast_sat_add($past(s.subst_val), $past(adc_trim));
  endproperty
  a_subst_used: assert property (p_subst_used) else $error("substitute not trimmed into result");
  property p_raw_used;
    adc_raw_valid && !s.subst_en |=> conv_result == ast_pkg::ast_sat_add($past(adc_raw), $past(adc_trim));
  endproperty
  a_raw_used: assert property (p_raw_used) else $error("raw result wrong");
  property p_full_scale;
    adc_raw_valid && s.subst_en && s.subst_val == ast_pkg::CONV_MAX && !adc_trim[13] |=>
      conv_result == ast_pkg::CONV_MAX;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("positive code not clipped at full scale");
  property p_rsvd_read;
    s.rvalid |-> s.rresp != ast_pkg::RESP_OKAY || !$past(ar_fire) ||
      word_idx($past(s_axi_araddr)) != ast_pkg::IDX_SUBST || s.rdata[22:14] == 9'h000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved substitute bits read nonzero");
  property p_fault_request;
    s_ctrl_write and s.wdata[ast_pkg::CTRL_FULL_BIT] |=> ##1 cal.full_busy;
  endproperty
  a_fault_request: assert property (p_fault_request) else $error("full test not started");
endmodule : ast_self_test

// >>> tb/ast_self_test_test.sv
// Self-checking bench for the ADC and protection self-test block.
// Assumes the bench alone drives the register bus, converter and calibration engine ports.
`timescale 1ns/1ps
module ast_self_test_test;
  logic        clk_sys = 1'b0;
  logic        rstn    = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata  = 32'h0;
  logic [3:0]  s_axi_wstrb  = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        adc_raw_valid = 1'b0, cal_eng_done = 1'b0, cal_eng_pass = 1'b0;
  logic [13:0] adc_raw = 14'h0, adc_trim = 14'h0, conv_result;
  logic        conv_valid, cal_eng_start, cal_eng_abort, cal_eng_partial, cal_eng_store_enable;
  logic        digital_die_thermal_trip, analog_die_thermal_trip, transistor_overcurrent_trip, irq;
  int          errors = 0;
  int          checks = 0;
  int          n_start = 0, n_abort = 0;
  logic [33:0] q_rd[$];
  logic [13:0] q_cv[$];
  logic [1:0]  q_wr[$];
  logic [15:0] lf = 16'he612;
  logic        sub_en = 1'b0;
  logic [13:0] sub_val = 14'h0;
  localparam logic [11:0] A_CTRL = {ast_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_SUB  = {ast_pkg::IDX_SUBST, 2'b00};
  localparam logic [11:0] A_FLT  = {ast_pkg::IDX_FAULT, 2'b00};
  localparam logic [11:0] A_STA  = {ast_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MSK  = {ast_pkg::IDX_IRQ_MASK, 2'b00};

  ast_self_test u_ast_self_test (.*);

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // Next step of the stimulus sequence
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Own clipped adder, kept apart from the design's helper
  function automatic logic [13:0] clip(input logic [13:0] a, input logic [13:0] b);
    int s;
    s = $signed(a) + $signed(b);
    if (s > 8191) return 14'h1fff;
    if (s < -8192) return 14'h2000;
    return s[13:0];
  endfunction : clip

  task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_cv(input logic [13:0] got, input logic [13:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t conv got %h exp %h", $time, got, exp);
    end
  endtask : cmp_cv

  task automatic cmp_lvl(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t level got %h exp %h", $time, got, exp);
    end
  endtask : cmp_lvl

  // Write with both address and data offered together; response noted for the monitor
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic ta, tw, aw_ok, w_ok;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    q_wr.push_back(r);
    while (!(ta && tw)) begin
      @(negedge clk_sys);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok  = s_axi_wvalid && s_axi_wready;
      @(posedge clk_sys);
      if (aw_ok) begin s_axi_awvalid <= 1'b0; ta = 1'b1; end
      if (w_ok) begin s_axi_wvalid <= 1'b0; tw = 1'b1; end
    end
    do begin @(negedge clk_sys); aw_ok = s_axi_bvalid; @(posedge clk_sys); end while (!aw_ok);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read; expected response and data noted for the monitor
  task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
    logic ok;
    @(posedge clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    q_rd.push_back({r, d});
    do begin @(negedge clk_sys); ok = s_axi_arready; @(posedge clk_sys); end while (!ok);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge clk_sys); ok = s_axi_rvalid; @(posedge clk_sys); end while (!ok);
    s_axi_rready <= 1'b0;
  endtask : rd

  // One conversion with a fresh random raw code and trim
  task automatic conv();
    lf = lfsr(lf);
    @(posedge clk_sys);
    adc_raw_valid <= 1'b1; adc_raw <= lf[13:0]; adc_trim <= {{6{lf[15]}}, lf[7:0]};
    q_cv.push_back(clip(sub_en ? sub_val : lf[13:0], {{6{lf[15]}}, lf[7:0]}));
    @(posedge clk_sys);
    adc_raw_valid <= 1'b0;
  endtask : conv

  task automatic done(input logic p);
    @(posedge clk_sys);
    cal_eng_done <= 1'b1; cal_eng_pass <= p;
    @(posedge clk_sys);
    cal_eng_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : done

  task automatic sub_wr(input logic en, input logic [13:0] v);
    sub_en = en;
    sub_val = v;
    wr(A_SUB, {8'h0, en, 9'h0, v}, 4'hf, ast_pkg::RESP_OKAY);
  endtask : sub_wr

  task automatic stop_test();
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Monitor: each answer is matched against the oldest note of its kind
  always @(posedge clk_sys) begin
    // Engine strobes are counted, so a lost or extra test start shows up
    if (rstn && cal_eng_start === 1'b1) n_start++;
    if (rstn && cal_eng_abort === 1'b1) n_abort++;
    if (rstn && s_axi_rvalid === 1'b1 && s_axi_rready) begin
      if (q_rd.size() == 0) begin errors++; $display("[ERR] %0t read got %h exp %h", $time, s_axi_rdata, 0); end
      else cmp_rd({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
    end
    if (rstn && s_axi_bvalid === 1'b1 && s_axi_bready) begin
      if (q_wr.size() == 0) begin errors++; $display("[ERR] %0t resp got %h exp %h", $time, s_axi_bresp, 0); end
      else cmp_lvl({2'b00, s_axi_bresp}, {2'b00, q_wr.pop_front()});
    end
    if (rstn && conv_valid === 1'b1) begin
      if (q_cv.size() == 0) begin errors++; $display("[ERR] %0t conv got %h exp %h", $time, conv_result, 0); end
      else cmp_cv(conv_result, q_cv.pop_front());
    end
  end

  // Watchdog against a hung handshake
  initial begin
    #(20000 * 4);
    errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(A_SUB, ast_pkg::RESP_OKAY, 32'h0);
    rd(A_FLT, ast_pkg::RESP_OKAY, 32'h0);
    rd(12'hffc, ast_pkg::RESP_SLVERR, 32'h0);
    wr(12'hffc, 32'hffff_ffff, 4'hf, ast_pkg::RESP_SLVERR);
    wr(A_MSK, 32'h3, 4'hf, ast_pkg::RESP_OKAY);
    // Full test that fails, fault only at finish
    wr(A_CTRL, 32'h10, 4'hf, ast_pkg::RESP_OKAY);
    rd(A_CTRL, ast_pkg::RESP_OKAY, 32'h10);
    cmp_lvl({3'b0, cal_eng_store_enable}, 4'h1);
    rd(A_FLT, ast_pkg::RESP_OKAY, 32'h0);
    done(1'b0);
    rd(A_CTRL, ast_pkg::RESP_OKAY, 32'h0);
    rd(A_FLT, ast_pkg::RESP_OKAY, 32'h10);
    cmp_lvl({3'b0, irq}, 4'h1);
    rd(A_STA, ast_pkg::RESP_OKAY, 32'h3);
    rd(A_STA, ast_pkg::RESP_OKAY, 32'h0);
    cmp_lvl({3'b0, irq}, 4'h0);
    // Partial test preempted by full, then partial ignored during full
    wr(A_MSK, 32'h0, 4'hf, ast_pkg::RESP_OKAY);
    wr(A_CTRL, 32'h08, 4'hf, ast_pkg::RESP_OKAY);
    rd(A_CTRL, ast_pkg::RESP_OKAY, 32'h08);
    cmp_lvl({2'b0, cal_eng_partial, cal_eng_store_enable}, 4'h2);
    wr(A_CTRL, 32'h10, 4'hf, ast_pkg::RESP_OKAY);
    rd(A_CTRL, ast_pkg::RESP_OKAY, 32'h10);
    wr(A_CTRL, 32'h08, 4'hf, ast_pkg::RESP_OKAY);
    rd(A_CTRL, ast_pkg::RESP_OKAY, 32'h10);
    done(1'b1);
    rd(A_FLT, ast_pkg::RESP_OKAY, 32'h0);
    cmp_lvl({3'b0, irq}, 4'h0);
    rd(A_STA, ast_pkg::RESP_OKAY, 32'h1);
    // Each protection trip alone, then released
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, (i < 3) ? (32'h1 << i) : 32'h0, 4'hf, ast_pkg::RESP_OKAY);
      @(posedge clk_sys);
      cmp_lvl({1'b0, digital_die_thermal_trip, analog_die_thermal_trip, transistor_overcurrent_trip},
              (i < 3) ? (4'h1 << i) : 4'h0);
    end
    // Converter path: raw, then substitute at both code extremes and random values
    repeat (6) conv();
    sub_wr(1'b1, ast_pkg::CONV_MAX);
    rd(A_SUB, ast_pkg::RESP_OKAY, 32'h0080_1fff);
    repeat (6) conv();
    sub_wr(1'b1, ast_pkg::CONV_MIN);
    repeat (6) conv();
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      sub_wr(1'b1, lf[13:0]);
      conv();
    end
    sub_wr(1'b0, 14'h0);
    repeat (4) conv();
    repeat (10) @(posedge clk_sys);
    // Three tests started, one partial aborted, the late partial never started
    cmp_lvl({n_abort[1:0], n_start[1:0]}, 4'h7);
    if (q_rd.size() + q_wr.size() + q_cv.size() != 0) errors++;
    stop_test();
  end
endmodule : ast_self_test_test
